// file: hdl/spcs_serial_ctrl.sv
// Function
// [RQ1] Modes 2 and 3 copy the received ninth bit into the receive ninth bit.
// [RQ2] Mode 1 with multiprocessor mode off stores the received stop bit there.
// [RQ3] In mode 0 received traffic never touches the receive ninth bit.
// [RQ4] The transmit flag sets at bit 8 end in mode 0, else at stop start.
// [RQ5] Mode 0 sets the receive flag after bit 8; only a write of 0 clears it.
// [RQ6] Reset clears the control byte, which is also writable bit by bit.
// [RQ7] The serial request is the OR of the transmit and receive flags.
// [RQ8] Transmit and receive events are handled together in modes 1 to 3.
// [RQ9] With the framing check on, a bad stop bit sets the framing error flag.
// [RQ10] Only software or reset clears the framing error; good frames do not.
// [RQ11] With the framing check on, the receive flag rises on the stop bit.
// [RQ12] Frames count only while receive enable is set; else flags stay.
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module spcs_serial_ctrl (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire spcs_pkg::spcs_bus_s bus_i,
    input wire spcs_pkg::spcs_bitwr_s bitwr_i,
    input wire spcs_pkg::spcs_rx_ev_s rx_ev_i,
    input wire spcs_pkg::spcs_tx_ev_s tx_ev_i,
    output logic [spcs_pkg::DATA_W-1:0] rdata_o,
    output logic [1:0] mode_o,
    output logic rx_enable_o,
    output logic mp_enable_o,
    output logic tx_ninth_o,
    output logic framing_error_o,
    output logic serial_irq_o,
    output logic irq_o
);

    // ==========================================================
    // Helpers
    // ==========================================================
    // True in the three asynchronous modes.
    function automatic logic is_async(input spcs_pkg::spcs_mode_e m);
        return m != spcs_pkg::SPCS_MODE_SHIFT;
    endfunction : is_async

    // True in the two nine-bit modes.
    function automatic logic is_nine(input spcs_pkg::spcs_mode_e m);
        return m == spcs_pkg::SPCS_MODE_UART9F ||
            m == spcs_pkg::SPCS_MODE_UART9V;
    endfunction : is_nine

    logic [spcs_pkg::DATA_W-1:0] ctrl_ff;
    logic [spcs_pkg::DATA_W-1:0] nxt_ctrl;
    logic fe_ff;
    logic nxt_fe;
    logic fcs_ff;
    logic sirq_ff;
    logic [spcs_pkg::DATA_W-1:0] rdata_ff;
    logic [spcs_pkg::DATA_W-1:0] wmask;
    logic [spcs_pkg::DATA_W-1:0] wval;
    logic [spcs_pkg::DATA_W-1:0] ctrl_view;
    logic [spcs_pkg::EV_W-1:0] ev;
    logic [spcs_pkg::EV_W-1:0] status;
    logic [spcs_pkg::EV_W-1:0] mask;
    spcs_pkg::spcs_mode_e mode;
    logic ren;
    logic mp_en;
    logic ri_set;
    logic ti_set;
    logic fe_set;
    logic rx_ninth_load;
    logic rx_ninth_val;
    logic rx_flag_ev;
    logic mp_block;

    assign mode = spcs_pkg::spcs_mode_e'(
        {ctrl_ff[spcs_pkg::BIT_MODE_HI], ctrl_ff[spcs_pkg::BIT_MODE_LO]});
    assign ren = ctrl_ff[spcs_pkg::BIT_RX_EN];
    assign mp_en = ctrl_ff[spcs_pkg::BIT_MP_EN];

    // ==========================================================
    // Software write decode
    // ==========================================================
    // A byte write and a bit write in one cycle: the byte write wins.
    // [RQ6] bit level access
    always_comb begin
        wmask = spcs_pkg::ZERO_BYTE;
        wval = spcs_pkg::ZERO_BYTE;
        if (bus_i.wr && bus_i.addr == spcs_pkg::ADDR_CTRL) begin
            wmask = spcs_pkg::ALL_BITS;
            wval = bus_i.wdata;
        end else if (bitwr_i.wr) begin
            wmask[bitwr_i.idx] = 1'b1;
            wval[bitwr_i.idx] = bitwr_i.val;
        end
    end

    // ==========================================================
    // Receive side event decode
    // ==========================================================
    // Receive and transmit paths share no term, so both run at once.
    // [RQ8] independent rx path
    always_comb begin
        rx_flag_ev = 1'b0;
        mp_block = 1'b0;
        rx_ninth_load = 1'b0;
        rx_ninth_val = 1'b0;
        unique case (mode)
            spcs_pkg::SPCS_MODE_SHIFT: begin
                // [RQ5] mode 0 flag
                rx_flag_ev = rx_ev_i.data_end;
            end
            spcs_pkg::SPCS_MODE_UART8: begin
                // [RQ11] flag on stop
                rx_flag_ev = fcs_ff ? rx_ev_i.stop_seen : rx_ev_i.data_end;
                mp_block = mp_en && rx_ev_i.stop_seen && !rx_ev_i.stop_bit;
                // [RQ2] stop bit load
                rx_ninth_load = !mp_en && rx_ev_i.stop_seen;
                rx_ninth_val = rx_ev_i.stop_bit;
            end
            spcs_pkg::SPCS_MODE_UART9F,
            spcs_pkg::SPCS_MODE_UART9V: begin
                rx_flag_ev = fcs_ff ? rx_ev_i.stop_seen : rx_ev_i.data_end;
                mp_block = mp_en && !rx_ev_i.ninth;
                // [RQ1] ninth bit load
                rx_ninth_load = rx_ev_i.data_end;
                rx_ninth_val = rx_ev_i.ninth;
            end
        endcase
    end

    // Nothing from the line counts while reception is disabled.
    // [RQ12] receive gated
    assign ri_set = ren && rx_flag_ev && !mp_block;
    // [RQ9] framing error set
    assign fe_set = ren && fcs_ff && is_async(mode) &&
        rx_ev_i.stop_seen && !rx_ev_i.stop_bit;
    // [RQ4] transmit flag set
    assign ti_set = (mode == spcs_pkg::SPCS_MODE_SHIFT) ?
        tx_ev_i.eighth_end : tx_ev_i.stop_start;

    // ==========================================================
    // Serial control register
    // ==========================================================
    // Hardware sets win over a same-cycle software clear of a flag.
    always_comb begin
        nxt_ctrl = (ctrl_ff & ~wmask) | (wval & wmask);
        // Bit 7 writes go to the error flag while the check is on.
        if (fcs_ff) begin
            nxt_ctrl[spcs_pkg::BIT_MODE_HI] =
                ctrl_ff[spcs_pkg::BIT_MODE_HI];
        end
        // [RQ5] receive flag sticky
        nxt_ctrl[spcs_pkg::BIT_RX_IRQ] =
            nxt_ctrl[spcs_pkg::BIT_RX_IRQ] | ri_set;
        // [RQ4] transmit flag sticky
        nxt_ctrl[spcs_pkg::BIT_TX_IRQ] =
            nxt_ctrl[spcs_pkg::BIT_TX_IRQ] | ti_set;
        // [RQ3] mode 0 never loads
        if (ren && rx_ninth_load && is_async(mode)) begin
            nxt_ctrl[spcs_pkg::BIT_RX_NINTH] = rx_ninth_val;
        end
    end

    // [RQ6] reset clears control
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ctrl_ff <= spcs_pkg::CTRL_RESET;
        end else if (ce_i) begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // ==========================================================
    // Framing error flag and check select
    // ==========================================================
    always_comb begin
        nxt_fe = fe_ff;
        if (fcs_ff && wmask[spcs_pkg::BIT_MODE_HI]) begin
            nxt_fe = wval[spcs_pkg::BIT_MODE_HI];
        end
        // [RQ10] error stays set
        nxt_fe = nxt_fe | fe_set;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            fe_ff <= 1'b0;
        end else if (ce_i) begin
            fe_ff <= nxt_fe;
        end
    end

    // The select also decides what bit 7 of the control byte shows.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            fcs_ff <= 1'b0;
        end else if (ce_i && bus_i.wr && bus_i.addr == spcs_pkg::ADDR_CFG) begin
            fcs_ff <= bus_i.wdata[spcs_pkg::CFG_FRAME_CHECK];
        end
    end

    // ==========================================================
    // Interrupt status, mask and outputs
    // ==========================================================
    always_comb begin
        ev = spcs_pkg::EV_RESET;
        ev[spcs_pkg::EV_TX] = ti_set;
        ev[spcs_pkg::EV_RX] = ri_set;
        ev[spcs_pkg::EV_FE] = fe_set;
    end

    spcs_irq_unit spcs_irq_unit_inst (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .ev_i(ev),
        .rd_clr_i(bus_i.rd && bus_i.addr == spcs_pkg::ADDR_STAT),
        .mask_wr_i(bus_i.wr && bus_i.addr == spcs_pkg::ADDR_MASK),
        .mask_wdata_i(bus_i.wdata[spcs_pkg::EV_W-1:0]),
        .status_o(status),
        .mask_o(mask),
        .irq_o(irq_o)
    );

    // One cycle behind the flags, so the output comes from a flop.
    // [RQ7] serial request
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            sirq_ff <= 1'b0;
        end else if (ce_i) begin
            sirq_ff <= ctrl_ff[spcs_pkg::BIT_TX_IRQ] |
                ctrl_ff[spcs_pkg::BIT_RX_IRQ];
        end
    end

    // ==========================================================
    // Read port
    // ==========================================================
    always_comb begin
        ctrl_view = ctrl_ff;
        if (fcs_ff) begin
            ctrl_view[spcs_pkg::BIT_MODE_HI] = fe_ff;
        end
    end

    // Read data stand for one enabled cycle only and hold while ce_i is low; unmapped offsets read zero.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rdata_ff <= spcs_pkg::ZERO_BYTE;
        end else if (ce_i) begin
            rdata_ff <= spcs_pkg::ZERO_BYTE;
            if (bus_i.rd) begin
                unique case (bus_i.addr)
                    spcs_pkg::ADDR_CTRL: rdata_ff <= ctrl_view;
                    spcs_pkg::ADDR_STAT: rdata_ff <= {5'h00, status};
                    spcs_pkg::ADDR_MASK: rdata_ff <= {5'h00, mask};
                    spcs_pkg::ADDR_CFG: rdata_ff <= {7'h00, fcs_ff};
                    default: rdata_ff <= spcs_pkg::ZERO_BYTE;
                endcase
            end
        end
    end

    assign rdata_o = rdata_ff;
    assign mode_o = {ctrl_ff[spcs_pkg::BIT_MODE_HI],
        ctrl_ff[spcs_pkg::BIT_MODE_LO]};
    assign rx_enable_o = ctrl_ff[spcs_pkg::BIT_RX_EN];
    assign mp_enable_o = ctrl_ff[spcs_pkg::BIT_MP_EN];
    assign tx_ninth_o = ctrl_ff[spcs_pkg::BIT_TX_NINTH];
    assign framing_error_o = fe_ff;
    assign serial_irq_o = sirq_ff;

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    AST_NINTH_LOAD: assert property ( // [RQ1]
        ce_i && ren && is_nine(mode) && rx_ev_i.data_end |=>
        ctrl_ff[spcs_pkg::BIT_RX_NINTH] == $past(rx_ev_i.ninth))
        else $error("ninth bit not loaded");

    AST_STOP_LOAD: assert property ( // [RQ2]
        ce_i && ren && mode == spcs_pkg::SPCS_MODE_UART8 && !mp_en &&
        rx_ev_i.stop_seen |=>
        ctrl_ff[spcs_pkg::BIT_RX_NINTH] == $past(rx_ev_i.stop_bit))
        else $error("stop bit not stored");

    AST_SHIFT_NINTH: assert property ( // [RQ3]
        ce_i && mode == spcs_pkg::SPCS_MODE_SHIFT &&
        !wmask[spcs_pkg::BIT_RX_NINTH] |=>
        $stable(ctrl_ff[spcs_pkg::BIT_RX_NINTH]))
        else $error("ninth bit changed in mode 0");

    AST_TX_FLAG: assert property ( // [RQ4]
        ce_i && ((mode == spcs_pkg::SPCS_MODE_SHIFT) ?
        tx_ev_i.eighth_end : tx_ev_i.stop_start) |=>
        ctrl_ff[spcs_pkg::BIT_TX_IRQ] ##1 sirq_ff)
        else $error("transmit flag or request missing");

    AST_RX_HOLD: assert property ( // [RQ5]
        ce_i && ctrl_ff[spcs_pkg::BIT_RX_IRQ] &&
        !(wmask[spcs_pkg::BIT_RX_IRQ] && !wval[spcs_pkg::BIT_RX_IRQ]) |=>
        ctrl_ff[spcs_pkg::BIT_RX_IRQ])
        else $error("receive flag dropped without a write");

    AST_RESET_CLEAR: assert property ( // [RQ6]
        @(posedge clock_i) disable iff (1'b0)
        rst_i |=> ctrl_ff == spcs_pkg::CTRL_RESET && !fe_ff)
        else $error("control not cleared by reset");

    AST_SERIAL_REQ: assert property ( // [RQ7]
        ce_i |=> sirq_ff == ($past(ctrl_ff[spcs_pkg::BIT_TX_IRQ]) ||
        $past(ctrl_ff[spcs_pkg::BIT_RX_IRQ])))
        else $error("serial request wrong");

    AST_FE_SET: assert property ( // [RQ9]
        ce_i && ren && fcs_ff && is_async(mode) && rx_ev_i.stop_seen &&
        !rx_ev_i.stop_bit |=> fe_ff)
        else $error("framing error not flagged");

    AST_FE_KEEP: assert property ( // [RQ10]
        ce_i && fe_ff && !(fcs_ff && wmask[spcs_pkg::BIT_MODE_HI]) |=>
        fe_ff)
        else $error("framing error cleared by hardware");

    AST_RI_ON_STOP: assert property ( // [RQ11]
        ce_i && fcs_ff && mode == spcs_pkg::SPCS_MODE_UART8 &&
        rx_ev_i.data_end && !rx_ev_i.stop_seen &&
        !ctrl_ff[spcs_pkg::BIT_RX_IRQ] && !wmask[spcs_pkg::BIT_RX_IRQ] |=>
        !ctrl_ff[spcs_pkg::BIT_RX_IRQ])
        else $error("receive flag rose before stop bit");

    AST_REN_OFF: assert property ( // [RQ12]
        ce_i && !ren && !wmask[spcs_pkg::BIT_RX_IRQ] &&
        !wmask[spcs_pkg::BIT_RX_NINTH] && !wmask[spcs_pkg::BIT_MODE_HI] |=>
        $stable(ctrl_ff[spcs_pkg::BIT_RX_IRQ]) &&
        $stable(ctrl_ff[spcs_pkg::BIT_RX_NINTH]) && $stable(fe_ff))
        else $error("receive state changed while disabled");
endmodule : spcs_serial_ctrl
`default_nettype wire

// file: shared/spcs_pkg.sv
`default_nettype none
package spcs_pkg;

    // ==========================================================
    // Register map of the plain register port
    // ==========================================================
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_CFG = 4'h3;

    // ==========================================================
    // Serial control field positions and reset value
    // ==========================================================
    localparam int BIT_RX_IRQ = 0;
    localparam int BIT_TX_IRQ = 1;
    localparam int BIT_RX_NINTH = 2;
    localparam int BIT_TX_NINTH = 3;
    localparam int BIT_RX_EN = 4;
    localparam int BIT_MP_EN = 5;
    localparam int BIT_MODE_LO = 6;
    localparam int BIT_MODE_HI = 7;
    localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] ALL_BITS = 8'hFF;

    // ==========================================================
    // Configuration and event status layout
    // ==========================================================
    localparam int CFG_FRAME_CHECK = 0;
    localparam int EV_W = 3;
    localparam int EV_TX = 0;
    localparam int EV_RX = 1;
    localparam int EV_FE = 2;
    localparam logic [EV_W-1:0] EV_RESET = 3'h0;

    // Operating modes, coded as the two mode bits.
    typedef enum logic [1:0] {
        SPCS_MODE_SHIFT = 2'b00,
        SPCS_MODE_UART8 = 2'b01,
        SPCS_MODE_UART9F = 2'b10,
        SPCS_MODE_UART9V = 2'b11
    } spcs_mode_e;

    // Register port request.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } spcs_bus_s;

    // Single-bit write, as a bit-level instruction does it.
    typedef struct packed {
        logic wr;
        logic [2:0] idx;
        logic val;
    } spcs_bitwr_s;

    // Receive datapath events, one-cycle pulses with sampled bits.
    typedef struct packed {
        logic data_end;
        logic stop_seen;
        logic ninth;
        logic stop_bit;
    } spcs_rx_ev_s;

    // Transmit datapath events, one-cycle pulses.
    typedef struct packed {
        logic eighth_end;
        logic stop_start;
    } spcs_tx_ev_s;

endpackage : spcs_pkg
`default_nettype wire

// file: hdl/spcs_irq_unit.sv
`timescale 1ns/100ps
`default_nettype none
module spcs_irq_unit (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [spcs_pkg::EV_W-1:0] ev_i,
    input wire logic rd_clr_i,
    input wire logic mask_wr_i,
    input wire logic [spcs_pkg::EV_W-1:0] mask_wdata_i,
    output logic [spcs_pkg::EV_W-1:0] status_o,
    output logic [spcs_pkg::EV_W-1:0] mask_o,
    output logic irq_o
);

    logic [spcs_pkg::EV_W-1:0] status_ff;
    logic [spcs_pkg::EV_W-1:0] mask_ff;
    logic irq_ff;
    logic [spcs_pkg::EV_W-1:0] nxt_status;

    // ==========================================================
    // Sticky status, cleared by a read
    // ==========================================================
    // An event in the reading cycle survives the clear, so none is lost.
    always_comb begin
        nxt_status = ev_i | (status_ff & {spcs_pkg::EV_W{~rd_clr_i}});
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            status_ff <= spcs_pkg::EV_RESET;
        end else if (ce_i) begin
            status_ff <= nxt_status;
        end
    end

    // Mask register, same layout as the status.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            mask_ff <= spcs_pkg::EV_RESET;
        end else if (ce_i && mask_wr_i) begin
            mask_ff <= mask_wdata_i;
        end
    end

    // Registered level output, one cycle behind the status it reflects.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            irq_ff <= 1'b0;
        end else if (ce_i) begin
            irq_ff <= |(status_ff & mask_ff);
        end
    end

    assign status_o = status_ff;
    assign mask_o = mask_ff;
    assign irq_o = irq_ff;

endmodule : spcs_irq_unit
`default_nettype wire

// file: test/spcs_remote_node.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Remote serial node seen as receive datapath events
// ==========================================================
module spcs_remote_node (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic ninth_i,
    input wire logic stop_i,
    output var spcs_pkg::spcs_rx_ev_s rx_ev_o,
    output logic busy_o
);
    logic [2:0] step_ff;

    // One frame is five cycles long, steps 1 to 5, so frames never overlap.
    // Reset keeps the event pulses from starting out unknown.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            step_ff <= 3'h0;
        end else if (go_i) begin
            step_ff <= 3'h1;
        end else if (step_ff == 3'h5 || step_ff == 3'h0) begin
            step_ff <= 3'h0;
        end else begin
            step_ff <= step_ff + 3'h1;
        end
    end

    // Sampled bits are only valid beside a pulse; elsewhere they are
    // inverted so that a design that samples late sees wrong values.
    always_comb begin
        rx_ev_o.data_end = (step_ff == 3'h3);
        rx_ev_o.stop_seen = (step_ff == 3'h5);
        rx_ev_o.ninth = (step_ff == 3'h3 || step_ff == 3'h5) ? ninth_i
                                                               : ~ninth_i;
        rx_ev_o.stop_bit = (step_ff == 3'h5) ? stop_i : ~stop_i;
        busy_o = (step_ff != 3'h0);
    end
endmodule : spcs_remote_node
`default_nettype wire

// file: test/spcs_serial_ctrl_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
    n_mismatch++; $display("BAD %s expected %h seen %h", nm, ex, got); \
    end end
module spcs_serial_ctrl_test;
    logic clock_i, rst_i, ce_i, go, ninth, stopb, busy, mid;
    spcs_pkg::spcs_bus_s bus;
    spcs_pkg::spcs_bitwr_s bitwr;
    spcs_pkg::spcs_rx_ev_s rx_ev;
    spcs_pkg::spcs_tx_ev_s tx_ev;
    logic [7:0] rdata, v;
    logic [1:0] mode;
    logic ren, mpen, tx9, fe, sirq, irq;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;

    // ==========================================================
    // Design, partner and clock
    // ==========================================================
    spcs_serial_ctrl spcs_serial_ctrl_inst (.clock_i(clock_i),
        .rst_i(rst_i), .ce_i(ce_i), .bus_i(bus), .bitwr_i(bitwr),
        .rx_ev_i(rx_ev), .tx_ev_i(tx_ev), .rdata_o(rdata), .mode_o(mode),
        .rx_enable_o(ren), .mp_enable_o(mpen), .tx_ninth_o(tx9),
        .framing_error_o(fe), .serial_irq_o(sirq), .irq_o(irq));
    spcs_remote_node spcs_remote_node_inst (.clock_i(clock_i),
        .rst_i(rst_i), .go_i(go),
        .ninth_i(ninth), .stop_i(stopb), .rx_ev_o(rx_ev), .busy_o(busy));

    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end

    // A hang is cut short long after the run would end on its own.
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    // ==========================================================
    // Bus and event tasks
    // ==========================================================
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_i);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clock_i);
        bus.wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock_i);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clock_i);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd

    task automatic bw(input logic [2:0] i, input logic b);
        @(posedge clock_i);
        bitwr <= {1'b1, i, b};
        @(posedge clock_i);
        bitwr.wr <= 1'b0;
    endtask : bw

    task automatic txp(input logic e8, input logic ss);
        @(posedge clock_i);
        tx_ev <= {e8, ss};
        @(posedge clock_i);
        tx_ev <= 2'b00;
        @(posedge clock_i);
        #1;
    endtask : txp

    // Mid holds the request seen after data_end but before stop_seen.
    // The transmit pulse lands beside data_end so both paths fire at once.
    task automatic frame(input logic n9, input logic sb, input logic ts);
        @(posedge clock_i);
        go <= 1'b1;
        ninth <= n9;
        stopb <= sb;
        @(posedge clock_i);
        go <= 1'b0;
        repeat (2) @(posedge clock_i);
        tx_ev.stop_start <= ts;
        @(posedge clock_i);
        tx_ev.stop_start <= 1'b0;
        @(posedge clock_i);
        #1 mid = sirq;
        repeat (3) @(posedge clock_i);
        #1;
    endtask : frame

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_reset();
        rd(spcs_pkg::ADDR_CTRL, v); `CHK("ctrl", 8'h00, v)
        rd(spcs_pkg::ADDR_MASK, v); `CHK("mask", 8'h00, v)
        wr(4'hF, 8'hFF);
        rd(4'hF, v); `CHK("unmapped", 8'h00, v)
    endtask : t_reset

    task automatic t_ninth();
        wr(spcs_pkg::ADDR_MASK, 8'h07);
        wr(spcs_pkg::ADDR_CTRL, 8'h90);
        frame(1'b1, 1'b1, 1'b0);
        rd(spcs_pkg::ADDR_CTRL, v); `CHK("ctrl", 8'h95, v)
        `CHK("serial_irq", 1'b1, sirq)
        `CHK("irq", 1'b1, irq)
        rd(spcs_pkg::ADDR_STAT, v); `CHK("stat", 8'h02, v)
        repeat (2) @(posedge clock_i);
        #1 `CHK("irq", 1'b0, irq)
        wr(spcs_pkg::ADDR_CTRL, 8'h90);
        frame(1'b0, 1'b1, 1'b0);
        rd(spcs_pkg::ADDR_CTRL, v); `CHK("ctrl", 8'h91, v)
    endtask : t_ninth

    // Mode 1 stores the stop bit, not the ninth bit, into the receive ninth bit.
    task automatic t_stop();
        wr(spcs_pkg::ADDR_CTRL, 8'h50);
        frame(1'b0, 1'b1, 1'b0);
        rd(spcs_pkg::ADDR_CTRL, v); `CHK("ctrl", 8'h55, v)
        wr(spcs_pkg::ADDR_CTRL, 8'h54);
        frame(1'b1, 1'b0, 1'b0);
        rd(spcs_pkg::ADDR_CTRL, v); `CHK("ctrl", 8'h51, v)
    endtask : t_stop

    task automatic t_mode0();
        wr(spcs_pkg::ADDR_CTRL, 8'h14);
        frame(1'b0, 1'b0, 1'b0);
        repeat (20) @(posedge clock_i);
        rd(spcs_pkg::ADDR_CTRL, v); `CHK("ctrl", 8'h15, v)
        wr(spcs_pkg::ADDR_CTRL, 8'h14);
        rd(spcs_pkg::ADDR_CTRL, v); `CHK("ctrl", 8'h14, v)
    endtask : t_mode0

    task automatic t_tx();
        wr(spcs_pkg::ADDR_MASK, 8'h00);
        wr(spcs_pkg::ADDR_CTRL, 8'h00);
        rd(spcs_pkg::ADDR_STAT, v);
        txp(1'b1, 1'b0);
        `CHK("serial_irq", 1'b1, sirq)
        `CHK("irq", 1'b0, irq)
        rd(spcs_pkg::ADDR_CTRL, v); `CHK("ctrl", 8'h02, v)
        wr(spcs_pkg::ADDR_CTRL, 8'h40);
        rd(spcs_pkg::ADDR_CTRL, v); `CHK("ctrl", 8'h40, v)
        txp(1'b0, 1'b1);
        rd(spcs_pkg::ADDR_CTRL, v); `CHK("ctrl", 8'h42, v)
        wr(spcs_pkg::ADDR_CTRL, 8'h50);
        frame(1'b0, 1'b1, 1'b1);
        rd(spcs_pkg::ADDR_CTRL, v); `CHK("ctrl", 8'h57, v)
        rd(spcs_pkg::ADDR_STAT, v); `CHK("stat", 8'h03, v)
    endtask : t_tx

    task automatic t_ren_off();
        wr(spcs_pkg::ADDR_CTRL, 8'h80);
        frame(1'b1, 1'b1, 1'b0);
        rd(spcs_pkg::ADDR_CTRL, v); `CHK("ctrl", 8'h80, v)
        rd(spcs_pkg::ADDR_STAT, v); `CHK("stat", 8'h00, v)
    endtask : t_ren_off

    // A bad stop bit sticks until bit 7 is written with the check on.
    task automatic t_frame();
        wr(spcs_pkg::ADDR_CTRL, 8'h50);
        wr(spcs_pkg::ADDR_CFG, 8'h01);
        frame(1'b0, 1'b0, 1'b0);
        `CHK("mid_irq", 1'b0, mid)
        `CHK("fe", 1'b1, fe)
        `CHK("mode", 2'b01, mode)
        rd(spcs_pkg::ADDR_CTRL, v); `CHK("ctrl", 8'hD1, v)
        rd(spcs_pkg::ADDR_STAT, v); `CHK("stat", 8'h06, v)
        bw(3'h0, 1'b0);
        frame(1'b0, 1'b1, 1'b0);
        `CHK("mid_irq", 1'b0, mid)
        rd(spcs_pkg::ADDR_CTRL, v); `CHK("ctrl", 8'hD5, v)
        wr(spcs_pkg::ADDR_CTRL, 8'h50);
        `CHK("fe", 1'b0, fe)
        wr(spcs_pkg::ADDR_CTRL, 8'h28);
        `CHK("mp_tx9", 2'b11, {mpen, tx9})
        `CHK("ren", 1'b0, ren)
        @(posedge clock_i);
        rst_i <= 1'b1;
        @(posedge clock_i);
        rst_i <= 1'b0;
        rd(spcs_pkg::ADDR_CTRL, v); `CHK("ctrl", 8'h00, v)
    endtask : t_frame

    // Mode 3 with multiprocessor filter, read data lifetime, clock enable.
    task automatic t_hold();
        wr(spcs_pkg::ADDR_CTRL, 8'hF4);
        frame(1'b0, 1'b1, 1'b0);
        rd(spcs_pkg::ADDR_CTRL, v); `CHK("ctrl", 8'hF0, v)
        frame(1'b1, 1'b1, 1'b0);
        rd(spcs_pkg::ADDR_CTRL, v); `CHK("ctrl", 8'hF5, v)
        @(posedge clock_i);
        ce_i <= 1'b0;
        #1 `CHK("rdata_idle", 8'h00, rdata)
        txp(1'b0, 1'b1);
        ce_i <= 1'b1;
        rd(spcs_pkg::ADDR_CTRL, v); `CHK("ctrl", 8'hF5, v)
    endtask : t_hold

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        rst_i = 1'b1;
        ce_i = 1'b1;
        bus = '0;
        bitwr = '0;
        tx_ev = '0;
        go = 1'b0;
        ninth = 1'b0;
        stopb = 1'b1;
        repeat (3) @(posedge clock_i);
        rst_i <= 1'b0;
        t_reset();
        t_ninth();
        t_stop();
        t_mode0();
        t_tx();
        t_ren_off();
        t_frame();
        t_hold();
        tally_and_finish();
    end
endmodule : spcs_serial_ctrl_test
`default_nettype wire
